// ===== common/nfpc_pkg.sv
package nfpc_pkg;
    // ------------------------------------------------------------
    // Widths and constants
    // ------------------------------------------------------------
    localparam int ADDR_W = 23;
    localparam int DATA_W = 16;
    localparam int NBLK_W = 8;
    localparam logic [1:0] SYNC_TAP = 2'h0;
    localparam int READY_DELAY_NS = 200;
    localparam int CLK_PERIOD_NS = 10;
    localparam int READY_CYCLES = (READY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] READY_CNT = 8'(READY_CYCLES);
    localparam logic [3:0] CFG_RESET = 4'h0;
    localparam int CFG_EDGE_BIT = 0;
    localparam int CFG_WAIT_POL_BIT = 1;
    localparam int CFG_WAIT_EARLY_BIT = 2;
    localparam int CFG_WAIT_ROLE_BIT = 3;
    localparam logic [1:0] BUF_DEPTH = 2'h2;

    typedef enum logic [1:0]
    {
        NFPC_RESET = 2'b00,
        NFPC_READY = 2'b01,
        NFPC_ARMED = 2'b11,
        NFPC_RUN   = 2'b10
    } nfpc_state_type;

    typedef struct packed
    {
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } nfpc_cmd_type;
endpackage

// ===== core/nfpc_top.sv
`timescale 1ns/100ps
module nfpc_top
(
    input  wire logic                           clk_sys,          // System clock
    input  wire logic                           rst,              // Synchronous reset
    input  wire logic [nfpc_pkg::ADDR_W-1:0]    address_inputs,   // Address pins
    input  wire logic [nfpc_pkg::DATA_W-1:0]    data_lines_i,     // Data pins in
    output logic      [nfpc_pkg::DATA_W-1:0]    data_lines_o,     // Data pins out
    output logic                                data_lines_oe,    // Data drive enable
    input  wire logic                           chip_sel_n,       // Chip select
    input  wire logic                           out_en_n,         // Output enable
    input  wire logic                           write_en_n,       // Write strobe
    input  wire logic                           hardware_reset_n, // Reset pin
    input  wire logic                           write_prot_n,     // Write protect
    input  wire logic                           cfg_clk,          // Burst clock pin
    input  wire logic                           latch_en_n,       // Latch enable
    input  wire logic                           ready_i,          // Ready/wait pin in
    output logic                                ready_o,          // Ready/wait pin out
    output logic                                ready_oe,         // Ready/wait drive enable
    input  wire logic                           prog_volt_ok,     // Above lockout level
    input  wire logic                           async_mode,       // Asynchronous read mode
    input  wire logic [3:0]                     cfg_value,        // Configuration to load
    input  wire logic                           cfg_load,         // Load configuration
    input  wire logic [nfpc_pkg::NBLK_W-1:0]    lock_target,      // Block to change
    input  wire logic                           lock_set,         // Lock request
    input  wire logic                           lock_clear,       // Unlock request
    input  wire logic                           lockdown_set,     // Lock-down request
    output logic [(1<<nfpc_pkg::NBLK_W)-1:0]    block_locked,     // Lock state per block
    output logic                                cmd_valid,        // Command out valid
    input  wire logic                           cmd_ready,        // Command sink ready
    output nfpc_pkg::nfpc_cmd_type              cmd_word,         // Captured command
    output logic                                prog_start,       // Program/erase started
    output logic                                prog_allowed,     // Voltage sample at start
    output logic [nfpc_pkg::ADDR_W-1:0]         array_addr,       // Latched array address
    input  wire logic [nfpc_pkg::DATA_W-1:0]    array_data,       // Array word for address
    input  wire logic                           array_data_ok,    // Array word valid
    output logic                                standby           // Standby indication
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    localparam int NS = 8;
    logic [NS-1:0] raw_w, s1_q, s2_q, s3_q;
    logic [nfpc_pkg::ADDR_W-1:0] a1_q, a2_q;
    logic [nfpc_pkg::DATA_W-1:0] d1_q, d2_q;
    assign raw_w = {prog_volt_ok, ready_i, latch_en_n, cfg_clk, write_prot_n,
                    hardware_reset_n, write_en_n, chip_sel_n};
    always_ff @(posedge clk_sys)
    begin
        s1_q <= raw_w;
        s2_q <= s1_q;
        s3_q <= s2_q;
        a1_q <= address_inputs;
        a2_q <= a1_q;
        d1_q <= data_lines_i;
        d2_q <= d1_q;
    end

    wire cs_n  = s2_q[0];
    wire we_n  = s2_q[1];
    wire rp_n  = s2_q[2];
    wire wp_n  = s2_q[3];
    wire lat_n = s2_q[5];
    wire rdy   = s2_q[6];
    wire vpp   = s2_q[7];
    wire oe_n_sync;
    logic oe1_q, oe2_q;
    always_ff @(posedge clk_sys)
    begin
        oe1_q <= out_en_n;
        oe2_q <= oe1_q;
    end
    assign oe_n_sync = oe2_q;

    wire k_rise   = s2_q[4] & ~s3_q[4];
    wire k_fall   = ~s2_q[4] & s3_q[4];
    wire cs_rise  = s2_q[0] & ~s3_q[0];
    wire we_rise  = s2_q[1] & ~s3_q[1];
    wire lat_rise = s2_q[5] & ~s3_q[5];
    wire in_reset = rst | ~rp_n;
    wire active   = ~cs_n & rp_n;

    // ------------------------------------------------------------
    // Configuration and state
    // ------------------------------------------------------------
    logic [3:0] cfg_q;
    nfpc_pkg::nfpc_state_type state_q, state_d;
    logic [7:0] cnt_q;
    always_ff @(posedge clk_sys)
    begin
        if (in_reset)
            cfg_q <= nfpc_pkg::CFG_RESET;
        else if (cfg_load)
            cfg_q <= cfg_value;
    end

    wire wait_role = cfg_q[nfpc_pkg::CFG_WAIT_ROLE_BIT];
    wire edge_sel  = cfg_q[nfpc_pkg::CFG_EDGE_BIT];
    wire k_edge    = edge_sel ? k_fall : k_rise;

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            nfpc_pkg::NFPC_RESET: if (cnt_q == nfpc_pkg::READY_CNT) state_d = nfpc_pkg::NFPC_READY;
            nfpc_pkg::NFPC_READY: if (rdy) state_d = nfpc_pkg::NFPC_ARMED;
            nfpc_pkg::NFPC_ARMED: if (k_rise) state_d = nfpc_pkg::NFPC_RUN;
            nfpc_pkg::NFPC_RUN:   if (!wait_role && !rdy) state_d = nfpc_pkg::NFPC_READY;
        endcase
    end
    always_ff @(posedge clk_sys)
    begin
        if (in_reset)
        begin
            state_q <= nfpc_pkg::NFPC_RESET;
            cnt_q   <= 8'h00;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= (cnt_q == nfpc_pkg::READY_CNT) ? cnt_q : cnt_q + 8'h01;
        end
    end
    wire ready_ok = (state_q == nfpc_pkg::NFPC_ARMED) | (state_q == nfpc_pkg::NFPC_RUN);

    // ------------------------------------------------------------
    // Address latch
    // ------------------------------------------------------------
    logic [nfpc_pkg::ADDR_W-1:0] addr_q;
    wire first_latch = (state_q == nfpc_pkg::NFPC_ARMED) & k_rise;
    wire async_take  = async_mode ? (~lat_n | lat_rise) : 1'b0;
    wire write_flow  = ~lat_n & ~we_n;
    wire sync_take   = ~async_mode & ~lat_n & k_edge & we_n;
    wire lat_take    = first_latch | async_take | write_flow | sync_take;
    wire burst_step = (state_q == nfpc_pkg::NFPC_RUN) & ~async_mode & lat_n & k_rise & ~lat_take;
    // Burst walks the latched address one word per clock rise
    always_ff @(posedge clk_sys)
    begin
        if (in_reset)
            addr_q <= '0;
        else if (lat_take)
            addr_q <= a2_q;
        else if (burst_step)
            addr_q <= addr_q + 23'h000001;
    end

    // ------------------------------------------------------------
    // Write capture
    // ------------------------------------------------------------
    logic wr_arm_q;
    wire wr_edge = wr_arm_q & (cs_rise | we_rise);
    always_ff @(posedge clk_sys)
    begin
        if (in_reset)
            wr_arm_q <= 1'b0;
        else if (wr_edge)
            wr_arm_q <= 1'b0;
        else if (~cs_n & ~we_n)
            wr_arm_q <= 1'b1;
    end
    nfpc_pkg::nfpc_cmd_type wr_cmd;
    assign wr_cmd = '{write: 1'b1, addr: lat_n ? addr_q : a2_q, data: d2_q};

    // ------------------------------------------------------------
    // Two-entry command buffer
    // ------------------------------------------------------------
    nfpc_pkg::nfpc_cmd_type buf_q [2];
    logic [1:0] cnt_b_q;
    logic rd_q, wr_p_q;
    // Output stage counts towards the two held words
    wire [1:0] held = cnt_b_q + {1'b0, cmd_valid};
    wire buf_full = held == nfpc_pkg::BUF_DEPTH;
    wire push = wr_edge & ready_ok & ~buf_full;
    wire pop  = (cnt_b_q != 2'h0) & (~cmd_valid | cmd_ready);
    always_ff @(posedge clk_sys)
    begin
        if (in_reset)
        begin
            cnt_b_q <= 2'h0;
            rd_q    <= 1'b0;
            wr_p_q  <= 1'b0;
        end
        else
        begin
            if (push)
            begin
                buf_q[wr_p_q] <= wr_cmd;
                wr_p_q        <= ~wr_p_q;
            end
            if (pop)
                rd_q <= ~rd_q;
            cnt_b_q <= cnt_b_q + {1'b0, push} - {1'b0, pop};
        end
    end
    // Word stands until the sink takes it
    always_ff @(posedge clk_sys)
    begin
        if (in_reset)
        begin
            cmd_valid <= 1'b0;
            cmd_word  <= '0;
        end
        else if (pop)
        begin
            cmd_valid <= 1'b1;
            cmd_word  <= buf_q[rd_q];
        end
        else if (cmd_ready)
        begin
            cmd_valid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Lock state and program voltage
    // ------------------------------------------------------------
    logic [(1<<nfpc_pkg::NBLK_W)-1:0] down_q;
    wire frozen = ~wp_n & down_q[lock_target];
    always_ff @(posedge clk_sys)
    begin
        if (in_reset)
        begin
            block_locked <= '1;
            down_q       <= '0;
        end
        else if (ready_ok && !frozen)
        begin
            if (lock_set)
                block_locked[lock_target] <= 1'b1;
            else if (lock_clear)
                block_locked[lock_target] <= 1'b0;
            if (lockdown_set)
                down_q[lock_target] <= 1'b1;
        end
    end
    always_ff @(posedge clk_sys)
    begin
        prog_start <= ~in_reset & push;
        if (in_reset)
            prog_allowed <= 1'b0;
        else if (push)
            prog_allowed <= vpp;
    end

    // ------------------------------------------------------------
    // Read path and ready/wait pin
    // ------------------------------------------------------------
    wire read_on  = active & ~oe_n_sync & we_n & ready_ok;
    wire wait_now = ~array_data_ok;
    logic wait_early_q;
    // Normal timing lags the early one by a cycle
    wire wait_lvl = cfg_q[nfpc_pkg::CFG_WAIT_EARLY_BIT] ? wait_now : wait_early_q;
    wire wait_pin = wait_lvl ^ ~cfg_q[nfpc_pkg::CFG_WAIT_POL_BIT];
    wire rdy_drive = wait_role ? (active & ~oe_n_sync)
                     : (state_q == nfpc_pkg::NFPC_RESET);
    always_ff @(posedge clk_sys)
    begin
        if (in_reset)
        begin
            wait_early_q  <= 1'b0;
            array_addr    <= '0;
            data_lines_o  <= '0;
            data_lines_oe <= 1'b0;
        end
        else
        begin
            wait_early_q  <= wait_now;
            array_addr    <= addr_q;
            data_lines_o  <= array_data;
            data_lines_oe <= read_on & (async_mode | array_data_ok);
        end
    end

    // ------------------------------------------------------------
    // Ready/wait drive and standby
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        standby <= in_reset | cs_n;
        if (in_reset)
        begin
            ready_oe <= 1'b0;
            ready_o  <= 1'b0;
        end
        else
        begin
            ready_oe <= rdy_drive;
            ready_o  <= wait_role & wait_pin;
        end
    end
endmodule // nfpc_top

// ===== tb/nfpc_props.sv
`timescale 1ns/100ps
module nfpc_props
(
    input wire logic                   clk_sys,          // Clock
    input wire logic                   rst,              // Reset
    input wire logic                   chip_sel_n,       // Select
    input wire logic                   write_en_n,       // Strobe
    input wire logic                   hardware_reset_n, // Reset pin
    input wire logic                   ready_i,          // Ready level
    input wire logic                   ready_oe,         // Ready drive
    input wire logic                   prog_volt_ok,     // Voltage
    input wire logic [255:0]           block_locked,     // Locks
    input wire logic                   cmd_valid,        // Valid
    input wire logic                   cmd_ready,        // Ready
    input wire nfpc_pkg::nfpc_cmd_type cmd_word,         // Command
    input wire logic                   prog_start,       // Start
    input wire logic                   prog_allowed,     // Sample
    input wire logic                   data_lines_oe,    // Data drive
    input wire logic                   standby           // Standby
);
    // ------------------------------------------------------------
    // Pin behaviour
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_reset_state: assert property ($fell(rst) |-> &block_locked && standby && !cmd_valid)
        else $error("state after reset wrong");
    a_ready_hold: assert property ($fell(rst) |-> ##[0:4] ready_oe [*8] ##[1:30] !ready_oe)
        else $error("ready line hold wrong");
    a_desel_float: assert property (chip_sel_n [*4] |-> !data_lines_oe && standby)
        else $error("deselected outputs driven");
    a_pin_float: assert property ((!hardware_reset_n) [*4] |-> !data_lines_oe && !ready_oe && !cmd_valid)
        else $error("outputs driven in reset");
    a_cmd_hold: assert property (cmd_valid && !cmd_ready && hardware_reset_n |=> cmd_valid && $stable(cmd_word))
        else $error("stalled command lost");
    a_volt_high: assert property (prog_volt_ok [*8] ##1 prog_start |-> prog_allowed)
        else $error("program blocked at good voltage");
    a_volt_low: assert property ((!prog_volt_ok) [*8] ##1 prog_start |-> !prog_allowed)
        else $error("program allowed below lockout");
    a_write_cmd: assert property ($rose(write_en_n) && !chip_sel_n && !cmd_valid && ready_i && !ready_oe
        |-> ##[3:6] cmd_valid)
        else $error("write not captured");
endmodule // nfpc_props

// ===== tb/nfpc_host.sv
`timescale 1ns/100ps
module nfpc_host
(
    input  wire logic run,      // Frame active
    input  wire logic ready_oe, // Device pulls low
    input  wire logic restart,  // Host pulls low
    output logic      cfg_clk,  // Burst clock
    output logic      ready_i   // Ready line level
);
    // ------------------------------------------------------------
    // Pull-up on ready line, clock only inside frames
    // ------------------------------------------------------------
    assign ready_i = !ready_oe & !restart;
    initial
    begin
        cfg_clk = 1'b0;
        #3;
        forever
        begin
            #40;
            cfg_clk = run ? ~cfg_clk : 1'b0;
        end
    end
endmodule // nfpc_host

// ===== tb/tb_nfpc_top.sv
`timescale 1ns/100ps
module tb_nfpc_top;
    logic clk_sys, rst, chip_sel_n, out_en_n, write_en_n, hardware_reset_n, write_prot_n, latch_en_n;
    logic prog_volt_ok, async_mode, cfg_load, cmd_ready, lock_set, lock_clear, lockdown_set, run;
    logic cfg_clk, ready_i, ready_o, ready_oe, data_lines_oe, cmd_valid, prog_start, prog_allowed;
    logic standby, array_data_ok, restart;
    logic [nfpc_pkg::ADDR_W-1:0] address_inputs, array_addr;
    logic [nfpc_pkg::DATA_W-1:0] data_lines_i, data_lines_o, array_data;
    logic [3:0]                  cfg_value;
    logic [7:0]                  lock_target;
    logic [255:0]                block_locked;
    nfpc_pkg::nfpc_cmd_type      cmd_word;
    int                          failures, n_checks, cyc, n_rise;
    // ------------------------------------------------------------
    // Harness
    // ------------------------------------------------------------
    nfpc_top i_dut (.*);
    nfpc_host i_host (.run(run), .ready_oe(ready_oe), .restart(restart), .cfg_clk(cfg_clk), .ready_i(ready_i));
    assign array_data = array_addr[15:0] ^ 16'h5a5a;
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge cfg_clk) n_rise++;
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        if (failures == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        idle(1);
        s = 1'b0;
        idle(5);
    endtask
    task automatic t_write(input logic [22:0] a, input logic [15:0] d, input logic by_cs);
        address_inputs = a;
        data_lines_i = d;
        chip_sel_n = 1'b0;
        write_en_n = 1'b0;
        idle(3);
        if (by_cs) chip_sel_n = 1'b1;
        else write_en_n = 1'b1;
        idle(1);
        {chip_sel_n, write_en_n} = 2'h3;
        data_lines_i = ~d;
        idle(4);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        idle(2);
        check(&block_locked, 1'b1);
        check(ready_oe, 1'b1);
        idle(30);
        check(ready_oe, 1'b0);
    endtask
    task automatic t_burst();
        chip_sel_n = 1'b0;
        out_en_n = 1'b0;
        idle(2);
        n_rise = 0;
        run = 1'b1;
        idle(48);
        run = 1'b0;
        idle(8);
        check(array_addr, 23'h000100 + 23'(n_rise) - 23'h1);
        check(data_lines_oe, 1'b1);
        check(data_lines_o, 16'(23'h000100 + n_rise - 1) ^ 16'h5a5a);
    endtask
    task automatic t_hwreset();
        hardware_reset_n = 1'b0;
        idle(6);
        check(data_lines_oe, 1'b0);
        hardware_reset_n = 1'b1;
        idle(8);
        check(ready_oe, 1'b1);
        idle(30);
        check(&block_locked, 1'b1);
        chip_sel_n = 1'b1;
    endtask
    task automatic t_cmds();
        latch_en_n = 1'b0;
        run = 1'b1;
        t_write(23'h000aa0, 16'h1234, 1'b0);
        prog_volt_ok = 1'b0;
        idle(10);
        t_write(23'h7fffff, 16'hfedc, 1'b1);
        t_write(23'h000001, 16'h0001, 1'b0);
        idle(6);
        check(cmd_word, {1'b1, 23'h000aa0, 16'h1234});
        pulse(cmd_ready);
        check(cmd_word, {1'b1, 23'h7fffff, 16'hfedc});
        pulse(cmd_ready);
        check(cmd_valid, 1'b0);
        run = 1'b0;
    endtask
    task automatic t_lock();
        write_prot_n = 1'b0;
        lock_target = 8'h05;
        pulse(lockdown_set);
        pulse(lock_clear);
        check(block_locked[5], 1'b1);
        lock_target = 8'h06;
        pulse(lock_clear);
        check(block_locked[6], 1'b0);
        pulse(lock_set);
        check(block_locked[6], 1'b1);
        write_prot_n = 1'b1;
        lock_target = 8'h05;
        idle(4);
        pulse(lock_clear);
        check(block_locked[5], 1'b0);
    endtask
    task automatic t_async();
        async_mode = 1'b1;
        chip_sel_n = 1'b0;
        run = 1'b1;
        address_inputs = 23'h012345;
        idle(8);
        check(array_addr, 23'h012345);
        latch_en_n = 1'b1;
        idle(6);
        address_inputs = 23'h054321;
        idle(12);
        check(array_addr, 23'h012345);
    endtask
    task automatic t_restart();
        address_inputs = 23'h000200;
        restart = 1'b1;
        idle(4);
        restart = 1'b0;
        idle(8);
        n_rise = 0;
        run = 1'b1;
        idle(20);
        run = 1'b0;
        idle(8);
        check(array_addr, 23'h000200 + 23'(n_rise) - 23'h1);
    endtask
    task automatic t_wait();
        cfg_value = 4'h8;
        pulse(cfg_load);
        array_data_ok = 1'b0;
        idle(4);
        check(ready_oe, 1'b1);
        check(ready_o, 1'b0);
        array_data_ok = 1'b1;
        idle(3);
        check(ready_o, 1'b1);
        cfg_value = 4'ha;
        pulse(cfg_load);
        check(ready_o, 1'b0);
        out_en_n = 1'b1;
        idle(5);
        check(ready_oe, 1'b0);
    endtask
    initial
    begin
        {rst, chip_sel_n, out_en_n, write_en_n, hardware_reset_n, write_prot_n, latch_en_n} = 7'h7f;
        {prog_volt_ok, array_data_ok} = 2'h3;
        {async_mode, cfg_load, cmd_ready, lock_set, lock_clear, lockdown_set, run} = 7'h00;
        {cfg_value, lock_target} = 12'h000;
        address_inputs = 23'h000100;
        data_lines_i = 16'h0000;
        restart = 1'b0;
        failures = 0;
        n_checks = 0;
        cyc = 0;
        n_rise = 0;
        idle(10);
        rst = 1'b0;
        t_reset();
        t_burst();
        t_restart();
        t_hwreset();
        t_cmds();
        t_lock();
        t_async();
        t_wait();
        give_verdict();
    end
endmodule // tb_nfpc_top
bind nfpc_top nfpc_props i_props (.*);
